// ==== logic/mie_pkg.sv ====
// Shared constants and types for the instruction execution unit.
package mie_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FILE_DEPTH = 128;
  localparam int FILE_AW = 7;
  localparam int ROM_AW = 11;
  localparam int ROM_DW = 14;
  localparam int TPH_USED = 3;
  localparam int TDH_W = 6;
  localparam int APB_AW = 12;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_WORK = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_TMODE = 12'h00c;
  localparam logic [11:0] ADDR_TPH = 12'h010;
  localparam logic [11:0] ADDR_TDH = 12'h014;
  localparam logic [11:0] ADDR_WDOG = 12'h018;
  localparam logic [2:0] FILE_PAGE = 3'h1;
  localparam int FILE_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values and constant figures
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_TDH = 6'h00;
  localparam logic [7:0] PRE_LAST = 8'hff;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // Instruction codes carried in the command register.
  typedef enum logic [3:0] {
    OP_HALT = 4'h0,
    OP_SUBI = 4'h1,
    OP_SWAP = 4'h2,
    OP_TMW = 4'h3,
    OP_TMR = 4'h4,
    OP_TABLE = 4'h5,
    OP_XORF = 4'h6,
    OP_XORI = 4'h7
  } mie_op_t;

  // Command word: destination bit, instruction code, operand byte.
  typedef struct packed {
    logic dest;
    mie_op_t op;
    logic [7:0] oper;
  } mie_cmd_t;

  // Status flags, z in bit 0; halt appears above them on reads.
  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic carry;
    logic half_borrow_flag;
    logic zero;
  } mie_flags_t;

  localparam mie_flags_t RST_FLAGS = 5'h18;

  // Sequencer states, Gray coded along idle, execute, ROM wait.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ROMW = 2'b11
  } mie_state_t;

endpackage : mie_pkg

// ==== logic/mie_exec.sv ====
// Execution unit for a subset of an 8-bit controller instruction set.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mie_exec (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_pin,
  output logic [10:0] rom_addr,
  output logic rom_rd,
  input wire logic [13:0] rom_data,
  output logic halted
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mie_pkg::mie_state_t state_q;
  mie_pkg::mie_cmd_t cmd_q;
  mie_pkg::mie_flags_t flags_q;
  logic [7:0] work_q;
  logic [7:0] tmode_q;
  logic [7:0] tph_q;
  logic [5:0] tdh_q;
  logic [7:0] wdt_q;
  logic [7:0] pre_q;
  logic halt_q;
  logic idle_hold_q;
  logic wake_s1_q;
  logic wake_s2_q;
  logic [10:0] rom_addr_q;
  logic rom_rd_q;
  logic [31:0] prdata_q;
  logic [7:0] file_q [mie_pkg::FILE_DEPTH];
  logic acc_ok;
  logic wr_acc;
  logic file_sel;
  logic mapped;
  logic exec;
  logic [6:0] faddr;
  logic [7:0] fval;
  logic [7:0] swap_v;
  logic [7:0] xorf_v;
  logic [7:0] xori_v;
  logic [8:0] sub_sum;
  logic [4:0] sub_half;
  logic file_res_en;
  logic [7:0] file_res;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Accesses stall while an instruction runs and one cycle after.
  assign pready = (state_q == mie_pkg::ST_IDLE) && idle_hold_q;
  assign acc_ok = psel && penable && pready;
  assign wr_acc = acc_ok && pwrite;
  assign file_sel = paddr[11:9] == mie_pkg::FILE_PAGE;
  assign prdata = prdata_q;
  assign rom_addr = rom_addr_q;
  assign rom_rd = rom_rd_q;
  assign halted = halt_q;

  // Address decode; unmapped words answer with an error.
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (file_sel) begin
      rd_mux[7:0] = file_q[paddr[8:2]];
    end else if (paddr == mie_pkg::ADDR_CMD) begin
      rd_mux[12:0] = cmd_q;
    end else if (paddr == mie_pkg::ADDR_WORK) begin
      rd_mux[7:0] = work_q;
    end else if (paddr == mie_pkg::ADDR_STAT) begin
      rd_mux[5:0] = {halt_q, flags_q};
    end else if (paddr == mie_pkg::ADDR_TMODE) begin
      rd_mux[7:0] = tmode_q;
    end else if (paddr == mie_pkg::ADDR_TPH) begin
      rd_mux[7:0] = tph_q;
    end else if (paddr == mie_pkg::ADDR_TDH) begin
      rd_mux[5:0] = tdh_q;
    end else if (paddr == mie_pkg::ADDR_WDOG) begin
      rd_mux[15:0] = {pre_q, wdt_q};
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = acc_ok && !mapped;

  // Read data is sampled every selected cycle so it is fresh at pready.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      idle_hold_q <= 1'b0;
    end else begin
      idle_hold_q <= state_q == mie_pkg::ST_IDLE;
      if (psel) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  assign exec = state_q == mie_pkg::ST_EXEC;
  assign faddr = cmd_q.oper[6:0];
  assign fval = file_q[faddr];
  assign swap_v = {fval[3:0], fval[7:4]};
  assign xorf_v = work_q ^ fval;
  assign xori_v = work_q ^ cmd_q.oper;
  // Adding the inverted work register plus one gives the difference.
  assign sub_sum = {1'b0, cmd_q.oper} + {1'b0, ~work_q} + 9'h001;
  assign sub_half = {1'b0, cmd_q.oper[3:0]} + {1'b0, ~work_q[3:0]} + 5'h01;
  assign file_res = (cmd_q.op == mie_pkg::OP_SWAP) ? swap_v : xorf_v;
  assign file_res_en = exec && cmd_q.dest &&
      (cmd_q.op == mie_pkg::OP_SWAP || cmd_q.op == mie_pkg::OP_XORF);

  // Wake pin passes two flip-flops before use.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_pin;
      wake_s2_q <= wake_s1_q;
    end
  end

  // Sequencer: a command write launches one execute cycle unless halted.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= mie_pkg::ST_IDLE;
      cmd_q <= '0;
    end else begin
      case (state_q)
        mie_pkg::ST_IDLE: begin
          if (wr_acc && !file_sel && paddr == mie_pkg::ADDR_CMD) begin
            cmd_q <= pwdata[12:0];
            if (!halt_q) begin
              state_q <= mie_pkg::ST_EXEC;
            end
          end
        end
        mie_pkg::ST_EXEC: begin
          if (cmd_q.op == mie_pkg::OP_TABLE) begin
            state_q <= mie_pkg::ST_ROMW;
          end else begin
            state_q <= mie_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= mie_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Halt mode is entered by the halt instruction and left on wake.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_q <= 1'b0;
    end else if (exec && cmd_q.op == mie_pkg::OP_HALT) begin
      halt_q <= 1'b1;
    end else if (wake_s2_q) begin
      halt_q <= 1'b0;
    end
  end

  // Watchdog prescaler and counter run while not halted.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= mie_pkg::RST_BYTE;
      wdt_q <= mie_pkg::RST_BYTE;
    end else if (exec && cmd_q.op == mie_pkg::OP_HALT) begin
      pre_q <= mie_pkg::RST_BYTE;
      wdt_q <= mie_pkg::RST_BYTE;
    end else if (!halt_q) begin
      pre_q <= pre_q + mie_pkg::ONE_BYTE;
      if (pre_q == mie_pkg::PRE_LAST) begin
        wdt_q <= wdt_q + mie_pkg::ONE_BYTE;
      end
    end
  end

  // Work register: software writes, instruction results, table data.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= mie_pkg::RST_BYTE;
    end else if (state_q == mie_pkg::ST_ROMW) begin
      work_q <= rom_data[7:0];
    end else if (exec) begin
      case (cmd_q.op)
        mie_pkg::OP_SUBI: work_q <= sub_sum[7:0];
        mie_pkg::OP_TMR: work_q <= tmode_q;
        mie_pkg::OP_XORI: work_q <= xori_v;
        mie_pkg::OP_SWAP: begin
          if (!cmd_q.dest) begin
            work_q <= swap_v;
          end
        end
        mie_pkg::OP_XORF: begin
          if (!cmd_q.dest) begin
            work_q <= xorf_v;
          end
        end
        default: begin
        end
      endcase
    end else if (wr_acc && !file_sel && paddr == mie_pkg::ADDR_WORK) begin
      work_q <= pwdata[7:0];
    end
  end

  // Status flags; software may load zero, half and carry directly.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= mie_pkg::RST_FLAGS;
    end else if (exec) begin
      case (cmd_q.op)
        mie_pkg::OP_HALT: begin
          flags_q.timeout_flag_n <= 1'b1;
          flags_q.powerdown_flag_n <= 1'b0;
        end
        mie_pkg::OP_SUBI: begin
          flags_q.zero <= sub_sum[7:0] == mie_pkg::RST_BYTE;
          flags_q.half_borrow_flag <= sub_half[4];
          flags_q.carry <= sub_sum[8];
        end
        mie_pkg::OP_XORI: begin
          flags_q.zero <= xori_v == mie_pkg::RST_BYTE;
        end
        default: begin
        end
      endcase
    end else if (wr_acc && !file_sel && paddr == mie_pkg::ADDR_STAT) begin
      flags_q.zero <= pwdata[0];
      flags_q.half_borrow_flag <= pwdata[1];
      flags_q.carry <= pwdata[2];
    end
  end

  // Timer mode, pointer and table high data registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmode_q <= mie_pkg::RST_BYTE;
      tph_q <= mie_pkg::RST_BYTE;
      tdh_q <= mie_pkg::RST_TDH;
    end else begin
      if (exec && cmd_q.op == mie_pkg::OP_TMW) begin
        tmode_q <= work_q;
      end else if (wr_acc && !file_sel && paddr == mie_pkg::ADDR_TMODE) begin
        tmode_q <= pwdata[7:0];
      end
      if (wr_acc && !file_sel && paddr == mie_pkg::ADDR_TPH) begin
        tph_q <= pwdata[7:0];
      end
      if (state_q == mie_pkg::ST_ROMW) begin
        tdh_q <= rom_data[13:8];
      end
    end
  end

  // ROM request is launched in the execute cycle of a table read.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_addr_q <= '0;
      rom_rd_q <= 1'b0;
    end else begin
      rom_rd_q <= exec && cmd_q.op == mie_pkg::OP_TABLE;
      if (exec && cmd_q.op == mie_pkg::OP_TABLE) begin
        rom_addr_q <= {tph_q[2:0], work_q};
      end
    end
  end

  // File registers: instruction write-back has priority over the bus.
  always_ff @(posedge sys_clk) begin
    if (file_res_en) begin
      file_q[faddr] <= file_res;
    end else if (wr_acc && file_sel) begin
      file_q[paddr[8:2]] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence halt_s;
    exec && cmd_q.op == mie_pkg::OP_HALT;
  endsequence

  sequence table_s;
    exec && cmd_q.op == mie_pkg::OP_TABLE ##1 state_q == mie_pkg::ST_ROMW;
  endsequence

  halt_wdog_a: assert property (halt_s |=> wdt_q == 8'h00 && pre_q == 8'h00)
    else $error("watchdog not cleared by halt");
  halt_flags_a: assert property (halt_s |=> flags_q.timeout_flag_n &&
      !flags_q.powerdown_flag_n && flags_q[2:0] == $past(flags_q[2:0]))
    else $error("halt flag update wrong");
  halt_mode_a: assert property (halt_s |=> halt_q && state_q == mie_pkg::ST_IDLE)
    else $error("halt mode not entered");
  sub_result_a: assert property (exec && cmd_q.op == mie_pkg::OP_SUBI |=>
      work_q == 8'($past(cmd_q.oper) - $past(work_q)))
    else $error("subtract result wrong");
  sub_carry_a: assert property (exec && cmd_q.op == mie_pkg::OP_SUBI |=>
      flags_q.carry == ($past(cmd_q.oper) >= $past(work_q)))
    else $error("subtract carry wrong");
  swap_flags_a: assert property (exec && cmd_q.op == mie_pkg::OP_SWAP |=>
      $stable(flags_q))
    else $error("swap changed flags");
  dest_file_a: assert property (exec && cmd_q.dest && cmd_q.op == mie_pkg::OP_XORF |=>
      $stable(work_q) && file_q[$past(faddr)] == $past(xorf_v))
    else $error("file destination wrong");
  tm_write_a: assert property (exec && cmd_q.op == mie_pkg::OP_TMW |=>
      tmode_q == $past(work_q) && $stable(flags_q))
    else $error("timer mode write wrong");
  tm_read_a: assert property (exec && cmd_q.op == mie_pkg::OP_TMR |=>
      work_q == $past(tmode_q) && $stable(flags_q))
    else $error("timer mode read wrong");
  rom_addr_a: assert property (exec && cmd_q.op == mie_pkg::OP_TABLE |=>
      rom_rd && rom_addr == {$past(tph_q[2:0]), $past(work_q)})
    else $error("table address wrong");
  table_data_a: assert property (table_s |=> work_q == $past(rom_data[7:0]) &&
      tdh_q == $past(rom_data[13:8]) && state_q == mie_pkg::ST_IDLE && $stable(flags_q))
    else $error("table data wrong");
  xor_work_a: assert property (exec && !cmd_q.dest && cmd_q.op == mie_pkg::OP_XORF |=>
      work_q == $past(work_q ^ fval))
    else $error("file xor wrong");
  xori_zero_a: assert property (exec && cmd_q.op == mie_pkg::OP_XORI |=>
      work_q == $past(xori_v) && flags_q.zero == (work_q == 8'h00) &&
      flags_q[4:1] == $past(flags_q[4:1]))
    else $error("immediate xor wrong");

endmodule : mie_exec
`default_nettype wire

// ==== test/mie_rom_model.sv ====
// Behavioural program ROM that answers the execution unit's table reads.
`timescale 1ns/1ps
`default_nettype none
module mie_rom_model (
  input wire logic sys_clk,
  input wire logic [10:0] rom_addr,
  input wire logic rom_rd,
  output logic [13:0] rom_data
);
  // ----------------------------------------------------------------
  // Contents and bus release
  // ----------------------------------------------------------------
  logic [13:0] word;
  logic [13:0] last_q;

  // Each word carries its address pattern, so a wrong address gives a wrong word.
  // The upper six bits of the word are read as table high data.
  assign word = {rom_addr[10:8] ^ 3'h5, rom_addr[2:0], rom_addr[7:0] ^ 8'h9e};

  // Outside a read cycle the bus shows the inverse of its last word, never a stale copy.
  assign rom_data = rom_rd ? word : ~last_q;

  // Remembers the last word that was driven.
  always_ff @(posedge sys_clk) begin
    if (rom_rd) begin
      last_q <= word;
    end
  end
endmodule : mie_rom_model
`default_nettype wire

// ==== test/test_mcu_instruction_exec_subset.sv ====
// Self-checking testbench for the instruction execution unit.
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_exec_subset;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic wake_pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] rom_addr;
  logic rom_rd;
  logic [13:0] rom_data;
  logic halted;
  logic last_err;
  logic [31:0] rd_v;
  int bad_count = 0;
  int checks_done = 0;

  mie_exec mie_exec_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_pin(wake_pin), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data), .halted(halted));

  mie_rom_model mie_rom_model_i (.sys_clk(sys_clk), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data));

  // The clock toggles every 25 ns, a period of 50 ns.
  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  // Compares one word and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, holding the request until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd_v = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  // Issues one instruction through the command register.
  task automatic cmd(input mie_pkg::mie_op_t op, input logic dest, input logic [7:0] oper);
    mie_pkg::mie_cmd_t c;
    c = '{dest, op, oper};
    apb(1'b1, mie_pkg::ADDR_CMD, {19'h00000, c});
  endtask : cmd

  function automatic logic [11:0] fa(input logic [6:0] n);
    return {mie_pkg::FILE_PAGE, n, 2'b00};
  endfunction : fa

  // Checks only the three arithmetic flags of the status word.
  task automatic chk_flags(input logic [2:0] exp);
    rd(mie_pkg::ADDR_STAT);
    chk({29'h0, rd_v[2:0]}, {29'h0, exp});
  endtask : chk_flags

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values and an unmapped address.
  task automatic t_reset;
    rd(mie_pkg::ADDR_STAT);
    chk(rd_v, 32'h00000018);
    rd(12'h100);
    chk({31'h0, last_err}, 32'h00000001);
    chk(rd_v, 32'h00000000);
  endtask : t_reset

  // Halt clears the watchdog, sets the flags, stops and refuses commands until woken.
  task automatic t_halt;
    int n;
    wr(mie_pkg::ADDR_STAT, 32'h00000007);
    repeat (20) @(posedge sys_clk);
    rd(mie_pkg::ADDR_WDOG);
    chk({31'h0, rd_v != 32'h0}, 32'h00000001);
    cmd(mie_pkg::OP_HALT, 1'b0, 8'h00);
    rd(mie_pkg::ADDR_STAT);
    chk(rd_v, 32'h00000037);
    chk({31'h0, halted}, 32'h00000001);
    rd(mie_pkg::ADDR_WDOG);
    chk(rd_v, 32'h00000000);
    wr(mie_pkg::ADDR_WORK, 32'h00000011);
    cmd(mie_pkg::OP_XORI, 1'b0, 8'hff);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, 32'h00000011);
    wake_pin <= 1'b1;
    n = 0;
    while (halted !== 1'b0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    wake_pin <= 1'b0;
    chk({31'h0, halted}, 32'h00000000);
  endtask : t_halt

  // Immediate minus work register over a table of borrow cases.
  task automatic t_sub;
    logic [7:0] im[5] = '{8'h05, 8'h06, 8'h05, 8'h00, 8'h10};
    logic [7:0] wk[5] = '{8'h06, 8'h05, 8'h05, 8'hff, 8'h01};
    logic [7:0] r;
    for (int i = 0; i < 5; i++) begin
      r = im[i] - wk[i];
      wr(mie_pkg::ADDR_WORK, {24'h0, wk[i]});
      cmd(mie_pkg::OP_SUBI, 1'b0, im[i]);
      rd(mie_pkg::ADDR_WORK);
      chk(rd_v, {24'h0, r});
      chk_flags({im[i] >= wk[i], im[i][3:0] >= wk[i][3:0], r == 8'h00});
    end
  endtask : t_sub

  // Nibble swap at the top file address, both destinations.
  task automatic t_swap;
    wr(mie_pkg::ADDR_STAT, 32'h00000005);
    wr(fa(7'd127), 32'h000000a5);
    cmd(mie_pkg::OP_SWAP, 1'b1, 8'h7f);
    rd(fa(7'd127));
    chk(rd_v, 32'h0000005a);
    cmd(mie_pkg::OP_SWAP, 1'b0, 8'h7f);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, 32'h000000a5);
    rd(fa(7'd127));
    chk(rd_v, 32'h0000005a);
    chk_flags(3'h5);
  endtask : t_swap

  // Timer-0 mode register moves in both directions.
  task automatic t_tmode;
    wr(mie_pkg::ADDR_STAT, 32'h00000002);
    wr(mie_pkg::ADDR_WORK, 32'h000000aa);
    cmd(mie_pkg::OP_TMW, 1'b0, 8'h00);
    rd(mie_pkg::ADDR_TMODE);
    chk(rd_v, 32'h000000aa);
    wr(mie_pkg::ADDR_TMODE, 32'h00000055);
    cmd(mie_pkg::OP_TMR, 1'b0, 8'h00);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, 32'h00000055);
    chk_flags(3'h2);
  endtask : t_tmode

  // Table read from the address built of pointer and work register.
  task automatic t_table(input logic [7:0] tp, input logic [7:0] w);
    logic [10:0] a;
    logic [13:0] e;
    a = {tp[2:0], w};
    e = {a[10:8] ^ 3'h5, a[2:0], a[7:0] ^ 8'h9e};
    wr(mie_pkg::ADDR_STAT, 32'h00000003);
    wr(mie_pkg::ADDR_TPH, {24'h0, tp});
    wr(mie_pkg::ADDR_WORK, {24'h0, w});
    cmd(mie_pkg::OP_TABLE, 1'b0, 8'h00);
    // The ROM request is launched on the edge the command returns at, so look at mid-cycle.
    @(negedge sys_clk);
    chk({21'h0, rom_addr}, {21'h0, a});
    chk({31'h0, rom_rd}, 32'h00000001);
    @(posedge sys_clk);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, {24'h0, e[7:0]});
    rd(mie_pkg::ADDR_TDH);
    chk(rd_v, {26'h0, e[13:8]});
    chk({31'h0, rom_rd}, 32'h00000000);
    chk_flags(3'h3);
  endtask : t_table

  // File and immediate exclusive-OR, with the zero flag both ways.
  task automatic t_xor;
    wr(mie_pkg::ADDR_STAT, 32'h00000006);
    wr(fa(7'd0), 32'h000000a5);
    wr(mie_pkg::ADDR_WORK, 32'h000000f0);
    cmd(mie_pkg::OP_XORF, 1'b1, 8'h00);
    rd(fa(7'd0));
    chk(rd_v, 32'h00000055);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, 32'h000000f0);
    cmd(mie_pkg::OP_XORF, 1'b0, 8'h00);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, 32'h000000a5);
    chk_flags(3'h6);
    cmd(mie_pkg::OP_XORI, 1'b0, 8'ha5);
    rd(mie_pkg::ADDR_WORK);
    chk(rd_v, 32'h00000000);
    chk_flags(3'h7);
    cmd(mie_pkg::OP_XORI, 1'b0, 8'hff);
    chk_flags(3'h6);
  endtask : t_xor

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Holds reset for 16 cycles, then runs every scenario.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_halt();
    t_sub();
    t_swap();
    t_tmode();
    t_table(8'hfa, 8'h34);
    t_table(8'h07, 8'hff);
    t_xor();
    close_out();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("[ERR] %0t run did not finish in time", $time);
    close_out();
  end
endmodule : test_mcu_instruction_exec_subset
`default_nettype wire
